// File: include/apd_pkg.sv
// constants and types shared by the power, diagnostic and identify command unit
package apd_pkg;

  // ********************************************************
  // register bus
  // ********************************************************
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam logic [3:0] A_FEAT = 4'h0;
  localparam logic [3:0] A_SCNT = 4'h1;
  localparam logic [3:0] A_SNUM = 4'h2;
  localparam logic [3:0] A_CYLO = 4'h3;
  localparam logic [3:0] A_CYHI = 4'h4;
  localparam logic [3:0] A_DRHD = 4'h5;
  localparam logic [3:0] A_CMD = 4'h6;
  localparam logic [3:0] A_STAT = 4'h7;
  localparam logic [3:0] A_ERR = 4'h8;
  localparam logic [3:0] A_DATA = 4'h9;
  localparam logic [3:0] A_ISTAT = 4'ha;
  localparam logic [3:0] A_IEN = 4'hb;
  localparam logic [3:0] A_ICLR = 4'hc;
  localparam logic [3:0] A_CTRL = 4'hd;

  // ********************************************************
  // opcodes
  // ********************************************************
  localparam logic [7:0] OP_PWR_A = 8'h98;
  localparam logic [7:0] OP_PWR_B = 8'he5;
  localparam logic [7:0] OP_ERASE = 8'hc0;
  localparam logic [7:0] OP_DIAG = 8'h90;
  localparam logic [7:0] OP_FLUSH = 8'he7;
  localparam logic [7:0] OP_IDENT = 8'hec;

  // ********************************************************
  // result codes
  // ********************************************************
  localparam logic [7:0] PWR_STANDBY_SC = 8'h00;
  localparam logic [7:0] PWR_IDLE_SC = 8'hff;
  localparam logic [7:0] DIAG_OK = 8'h01;
  localparam logic [7:0] DIAG_FMT = 8'h02;
  localparam logic [7:0] DIAG_BUF = 8'h03;
  localparam logic [7:0] DIAG_ECC = 8'h04;
  localparam logic [7:0] DIAG_CPU = 8'h05;
  localparam logic [7:0] DIAG_PEER_FAIL = 8'h80;
  localparam logic [7:0] ERR_ABRT = 8'h04;
  localparam logic [7:0] ERR_NONE = 8'h00;

  // ********************************************************
  // field positions and reset values
  // ********************************************************
  localparam int unsigned ST_BSY = 7;
  localparam int unsigned ST_DRDY = 6;
  localparam int unsigned ST_DF = 5;
  localparam int unsigned ST_DSC = 4;
  localparam int unsigned ST_DRQ = 3;
  localparam int unsigned ST_ERR = 0;
  localparam int unsigned DH_DRV = 4;
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_DRQ = 1;
  localparam int unsigned EV_ERR = 2;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned CTRL_FLUSH_EN = 0;
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] TF_RST = 8'h00;
  localparam logic [7:0] DIAG_RST = 8'h01;
  localparam int unsigned ID_WORDS = 256;

  typedef enum logic [2:0] {
    APD_IDLE,
    APD_PWR,
    APD_ERASE,
    APD_DIAG,
    APD_FLUSH,
    APD_IDPREP,
    APD_IDXFER
  } apd_state_t;

endpackage

// File: logic/apd_ident_rom.sv
// parameter block returned by the identify command, one word per index
`timescale 1ns/100ps
module apd_ident_rom #(
  parameter int unsigned WORDS = apd_pkg::ID_WORDS,
  parameter logic [15:0] CONFIG_WORD = 16'h044a
) (
  input wire logic [$clog2(WORDS)-1:0] word_idx,
  output logic [15:0] word_val
);

  // ********************************************************
  // table lookup
  // ********************************************************
  // unlisted indices are reserved or left empty and read as zero
  always_comb
  begin
    unique case (word_idx)
      0: word_val = CONFIG_WORD;
      20: word_val = 16'h0002;
      21: word_val = 16'h0002;
      50: word_val = 16'h4000;
      51: word_val = 16'h0200;
      53: word_val = 16'h0007;
      64: word_val = 16'h0003;
      65: word_val = 16'h0078;
      66: word_val = 16'h0078;
      67: word_val = 16'h0078;
      68: word_val = 16'h0078;
      76: word_val = 16'h0006;
      78: word_val = 16'h0008;
      default: word_val = 16'h0000;
    endcase
  end

endmodule

// File: logic/apd_cmd_unit.sv
// task-file command unit for power query, pre-erase, diagnostic, flush, identify
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
// What this block does
// - opcodes 98h and E5h both query power
// - standby or transitioning: busy, count 00h, interrupt
// - idle: busy, count FFh, then interrupt
// - pre-erase moves no data, may write-fault
// - sector count gives number of blocks erased
// - diagnostic ignores drive bit, master reports both
// - diagnostic code lands in error register
// - flush completes media writes before ready status
// - unsupported flush ends with aborted command
// - identify returns one sector like read
// - reserved identify words and bits read zero
module apd_cmd_unit #(
  parameter logic DRIVE_ID = 1'b0,
  parameter int unsigned ID_WORDS = apd_pkg::ID_WORDS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [apd_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [apd_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [apd_pkg::DATA_W-1:0] bus_rdata,
  output logic irq,
  input wire logic pwr_standby,
  input wire logic pwr_transit,
  output logic erase_req,
  output logic [27:0] erase_lba,
  output logic [8:0] erase_count,
  input wire logic erase_done,
  input wire logic erase_fault,
  output logic diag_req,
  input wire logic diag_done,
  input wire logic [7:0] diag_code,
  input wire logic peer_diag_fail,
  output logic flush_req,
  input wire logic flush_done
);

  localparam int unsigned PTR_W = $clog2(ID_WORDS);

  // ********************************************************
  // elaboration checks
  // ********************************************************
  if (ID_WORDS < 2 || ID_WORDS > 256)
  begin : g_bad_words
    $error("identify block size out of range");
  end

  // ********************************************************
  // state
  // ********************************************************
  apd_pkg::apd_state_t state_q;
  logic [7:0] feat_q;
  logic [7:0] scnt_q;
  logic [7:0] snum_q;
  logic [7:0] cylo_q;
  logic [7:0] cyhi_q;
  logic [7:0] drhd_q;
  logic [7:0] err_q;
  logic [7:0] ctrl_q;
  logic busy_q;
  logic drq_q;
  logic df_q;
  logic errb_q;
  logic [PTR_W-1:0] ptr_q;
  logic [apd_pkg::IRQ_W-1:0] ev_q;
  logic [apd_pkg::IRQ_W-1:0] istat_q;
  logic [apd_pkg::IRQ_W-1:0] ien_q;
  logic [apd_pkg::IRQ_W-1:0] iclr;
  logic [15:0] id_word;
  logic [7:0] status;
  logic host_wr;
  logic cmd_wr;
  logic data_rd;
  logic drive_hit;

  // the host may write the task file only while no command runs
  assign host_wr = bus_wr && state_q == apd_pkg::APD_IDLE;
  assign cmd_wr = host_wr && bus_addr == apd_pkg::A_CMD;
  assign data_rd = bus_rd && bus_addr == apd_pkg::A_DATA && state_q == apd_pkg::APD_IDXFER;
  // only the drive bit of drive/head matters for most opcodes
  assign drive_hit = drhd_q[apd_pkg::DH_DRV] == DRIVE_ID;
  assign iclr = (bus_wr && bus_addr == apd_pkg::A_ICLR) ? bus_wdata[apd_pkg::IRQ_W-1:0] : '0;

  assign status = {busy_q, 1'b1, df_q, 1'b1, drq_q, 2'b00, errb_q};

  // true for the two equivalent power query codes
  function automatic logic is_pwr(input logic [7:0] op);
    is_pwr = op == apd_pkg::OP_PWR_A || op == apd_pkg::OP_PWR_B;
  endfunction

  // ********************************************************
  // identify parameter table
  // ********************************************************
  apd_ident_rom #(
    .WORDS(ID_WORDS)
  ) u_rom (
    .word_idx(ptr_q),
    .word_val(id_word)
  );

  // ********************************************************
  // parameter task file
  // ********************************************************
  // host writes land here; the power query overwrites sector count
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      feat_q <= apd_pkg::TF_RST;
      snum_q <= apd_pkg::TF_RST;
      cylo_q <= apd_pkg::TF_RST;
      cyhi_q <= apd_pkg::TF_RST;
      drhd_q <= apd_pkg::TF_RST;
      ctrl_q <= apd_pkg::CTRL_RST;
    end
    else if (host_wr)
    begin
      unique case (bus_addr)
        apd_pkg::A_FEAT: feat_q <= bus_wdata[7:0];
        apd_pkg::A_SNUM: snum_q <= bus_wdata[7:0];
        apd_pkg::A_CYLO: cylo_q <= bus_wdata[7:0];
        apd_pkg::A_CYHI: cyhi_q <= bus_wdata[7:0];
        apd_pkg::A_DRHD: drhd_q <= bus_wdata[7:0];
        apd_pkg::A_CTRL: ctrl_q <= bus_wdata[7:0];
        default: ;
      endcase
    end
  end

  // sector count is shared by the host and the power query result
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      scnt_q <= apd_pkg::TF_RST;
    else if (state_q == apd_pkg::APD_PWR)
      scnt_q <= (pwr_standby || pwr_transit) ? apd_pkg::PWR_STANDBY_SC
                                             : apd_pkg::PWR_IDLE_SC;
    else if (host_wr && bus_addr == apd_pkg::A_SCNT)
      scnt_q <= bus_wdata[7:0];
  end

  // ********************************************************
  // command sequencer
  // ********************************************************
  // one command at a time; a new opcode is taken only from idle
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= apd_pkg::APD_IDLE;
      busy_q <= 1'b0;
      drq_q <= 1'b0;
      df_q <= 1'b0;
      errb_q <= 1'b0;
      err_q <= apd_pkg::DIAG_RST;
      ptr_q <= '0;
      ev_q <= '0;
      erase_req <= 1'b0;
      erase_lba <= '0;
      erase_count <= '0;
      diag_req <= 1'b0;
      flush_req <= 1'b0;
    end
    else
    begin
      ev_q <= '0;
      unique case (state_q)
        apd_pkg::APD_IDLE:
        begin
          if (cmd_wr)
          begin
            df_q <= 1'b0;
            errb_q <= 1'b0;
            err_q <= apd_pkg::ERR_NONE;
            if (bus_wdata[7:0] == apd_pkg::OP_DIAG)
            begin
              // runs whatever the drive bit says
              busy_q <= 1'b1;
              diag_req <= 1'b1;
              state_q <= apd_pkg::APD_DIAG;
            end
            else if (!drive_hit)
            begin
              // addressed to the other drive: leave everything alone
              df_q <= df_q;
              errb_q <= errb_q;
              err_q <= err_q;
            end
            else if (is_pwr(bus_wdata[7:0]))
            begin
              busy_q <= 1'b1;
              state_q <= apd_pkg::APD_PWR;
            end
            else if (bus_wdata[7:0] == apd_pkg::OP_ERASE)
            begin
              busy_q <= 1'b1;
              erase_req <= 1'b1;
              erase_lba <= {drhd_q[3:0], cyhi_q, cylo_q, snum_q};
              // a zero count asks for the full 256 blocks
              erase_count <= (scnt_q == 8'h00) ? 9'h100 : {1'b0, scnt_q};
              state_q <= apd_pkg::APD_ERASE;
            end
            else if (bus_wdata[7:0] == apd_pkg::OP_FLUSH && ctrl_q[apd_pkg::CTRL_FLUSH_EN])
            begin
              busy_q <= 1'b1;
              flush_req <= 1'b1;
              state_q <= apd_pkg::APD_FLUSH;
            end
            else if (bus_wdata[7:0] == apd_pkg::OP_IDENT)
            begin
              busy_q <= 1'b1;
              ptr_q <= '0;
              state_q <= apd_pkg::APD_IDPREP;
            end
            else
            begin
              // unsupported flush and unknown opcodes are aborted at once
              errb_q <= 1'b1;
              err_q <= apd_pkg::ERR_ABRT;
              ev_q[apd_pkg::EV_DONE] <= 1'b1;
              ev_q[apd_pkg::EV_ERR] <= 1'b1;
            end
          end
        end
        apd_pkg::APD_PWR:
        begin
          // sector count is loaded this same cycle
          busy_q <= 1'b0;
          ev_q[apd_pkg::EV_DONE] <= 1'b1;
          state_q <= apd_pkg::APD_IDLE;
        end
        apd_pkg::APD_ERASE:
        begin
          if (erase_done)
          begin
            erase_req <= 1'b0;
            busy_q <= 1'b0;
            df_q <= erase_fault;
            errb_q <= erase_fault;
            ev_q[apd_pkg::EV_DONE] <= 1'b1;
            ev_q[apd_pkg::EV_ERR] <= erase_fault;
            state_q <= apd_pkg::APD_IDLE;
          end
        end
        apd_pkg::APD_DIAG:
        begin
          if (diag_done)
          begin
            diag_req <= 1'b0;
            busy_q <= 1'b0;
            // the master folds the other drive's result into its code
            err_q <= diag_code | (peer_diag_fail ? apd_pkg::DIAG_PEER_FAIL
                                                 : apd_pkg::ERR_NONE);
            ev_q[apd_pkg::EV_DONE] <= 1'b1;
            state_q <= apd_pkg::APD_IDLE;
          end
        end
        apd_pkg::APD_FLUSH:
        begin
          // ready status is posted only once the media side reports done
          if (flush_done)
          begin
            flush_req <= 1'b0;
            busy_q <= 1'b0;
            ev_q[apd_pkg::EV_DONE] <= 1'b1;
            state_q <= apd_pkg::APD_IDLE;
          end
        end
        apd_pkg::APD_IDPREP:
        begin
          // same hand-off as a sector read: drop busy, raise drq, interrupt
          busy_q <= 1'b0;
          drq_q <= 1'b1;
          ev_q[apd_pkg::EV_DRQ] <= 1'b1;
          state_q <= apd_pkg::APD_IDXFER;
        end
        apd_pkg::APD_IDXFER:
        begin
          if (data_rd)
          begin
            ptr_q <= ptr_q + PTR_W'(1);
            if (ptr_q == PTR_W'(ID_WORDS - 1))
            begin
              // the whole sector has been taken
              drq_q <= 1'b0;
              ev_q[apd_pkg::EV_DONE] <= 1'b1;
              state_q <= apd_pkg::APD_IDLE;
            end
          end
        end
        default:
          state_q <= apd_pkg::APD_IDLE;
      endcase
    end
  end

  // ********************************************************
  // interrupt status, enable and output
  // ********************************************************
  // a new event beats a clear written in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      istat_q <= '0;
    else
      istat_q <= (istat_q & ~iclr) | ev_q;
  end

  // enable register has the same layout as the status register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ien_q <= '0;
    else if (bus_wr && bus_addr == apd_pkg::A_IEN)
      ien_q <= bus_wdata[apd_pkg::IRQ_W-1:0];
  end

  // level output, one cycle behind the status bits it reflects
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(istat_q & ien_q);
  end

  // ********************************************************
  // read path
  // ********************************************************
  // data valid the cycle after the strobe; unmapped and write-only read zero
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      bus_rdata <= '0;
    else if (bus_rd)
    begin
      unique case (bus_addr)
        apd_pkg::A_FEAT: bus_rdata <= {8'h00, feat_q};
        apd_pkg::A_SCNT: bus_rdata <= {8'h00, scnt_q};
        apd_pkg::A_SNUM: bus_rdata <= {8'h00, snum_q};
        apd_pkg::A_CYLO: bus_rdata <= {8'h00, cylo_q};
        apd_pkg::A_CYHI: bus_rdata <= {8'h00, cyhi_q};
        apd_pkg::A_DRHD: bus_rdata <= {8'h00, drhd_q};
        apd_pkg::A_STAT: bus_rdata <= {8'h00, status};
        apd_pkg::A_ERR: bus_rdata <= {8'h00, err_q};
        // outside a transfer the data port reads zero
        apd_pkg::A_DATA: bus_rdata <= data_rd ? id_word : 16'h0000;
        apd_pkg::A_ISTAT: bus_rdata <= {13'h0000, istat_q};
        apd_pkg::A_IEN: bus_rdata <= {13'h0000, ien_q};
        apd_pkg::A_CTRL: bus_rdata <= {8'h00, ctrl_q};
        default: bus_rdata <= 16'h0000;
      endcase
    end
  end

endmodule

// File: test/apd_cmd_unit_assertions.sv
// port-level checks on the command unit
`timescale 1ns/100ps
module apd_cmd_unit_assertions (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [apd_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [apd_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic erase_req,
  input wire logic [27:0] erase_lba,
  input wire logic erase_done,
  input wire logic diag_req,
  input wire logic diag_done,
  input wire logic flush_req,
  input wire logic flush_done
);
  // ****************************************
  // request timing
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic cmd_wr;
  // opcode write seen on the bus
  assign cmd_wr = bus_wr && bus_addr == apd_pkg::A_CMD;
  AST_ERASE_GO: assert property ($rose(erase_req) |-> $past(cmd_wr && bus_wdata[7:0] == 8'hc0))
    else $error("erase started without its opcode");
  AST_DIAG_GO: assert property ($rose(diag_req) |-> $past(cmd_wr && bus_wdata[7:0] == 8'h90))
    else $error("diagnostic started without its opcode");
  AST_FLUSH_GO: assert property ($rose(flush_req) |-> $past(cmd_wr && bus_wdata[7:0] == 8'he7))
    else $error("flush started without its opcode");
  AST_ERASE_HOLD: assert property (erase_req && !erase_done |=> erase_req)
    else $error("erase request dropped early");
  AST_ERASE_END: assert property (erase_req && erase_done |=> !erase_req)
    else $error("erase request outlived done");
  AST_LBA_HOLD: assert property (erase_req && $past(erase_req) |-> $stable(erase_lba))
    else $error("erase address moved");
  AST_FLUSH_WAIT: assert property (flush_req && !flush_done |=> flush_req)
    else $error("flush ended before media done");
  AST_FLUSH_END: assert property (flush_req && flush_done |=> !flush_req)
    else $error("flush request outlived done");
  AST_DIAG_END: assert property (diag_req && diag_done |=> !diag_req)
    else $error("diagnostic request outlived done");
  AST_ONE_REQ: assert property ($onehot0({erase_req, diag_req, flush_req}))
    else $error("two back-end requests at once");
endmodule
bind apd_cmd_unit apd_cmd_unit_assertions apd_cmd_unit_assertions_inst (.sys_clk, .rst,
  .bus_addr, .bus_wdata, .bus_wr, .erase_req, .erase_lba, .erase_done, .diag_req,
  .diag_done, .flush_req, .flush_done);

// File: test/apd_media_model.sv
// back-end model answering erase, diagnostic and flush requests
`timescale 1ns/100ps
module apd_media_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic erase_req,
  input wire logic diag_req,
  input wire logic flush_req,
  input wire logic [3:0] dly,
  input wire logic fault_in,
  input wire logic [7:0] code_in,
  input wire logic peer_in,
  output logic erase_done,
  output logic erase_fault,
  output logic diag_done,
  output logic [7:0] diag_code,
  output logic peer_diag_fail,
  output logic flush_done
);
  logic [3:0] cnt_q;
  logic fire_q;
  logic busy;
  assign busy = erase_req | diag_req | flush_req;
  // count dly cycles, then one done pulse; cleared so a held request fires again only after another dly count
  always_ff @(posedge sys_clk)
  begin
    cnt_q <= (rst || !busy || fire_q) ? 4'h0 : (cnt_q == dly ? cnt_q : cnt_q + 4'h1);
    fire_q <= !rst && busy && !fire_q && cnt_q == dly;
  end
  // qualifiers only mean something with done; otherwise show the inverse
  assign erase_done = fire_q & erase_req;
  assign flush_done = fire_q & flush_req;
  assign diag_done = fire_q & diag_req;
  assign erase_fault = fire_q ? fault_in : ~fault_in;
  assign diag_code = fire_q ? code_in : ~code_in;
  assign peer_diag_fail = fire_q ? peer_in : ~peer_in;
endmodule

// File: test/apd_cmd_unit_tb.sv
// self-checking bench for the command unit
`timescale 1ns/100ps
module apd_cmd_unit_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] bus_addr = 4'h0;
  logic [15:0] bus_wdata = 16'h0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic pwr_standby = 1'b0;
  logic pwr_transit = 1'b0;
  logic [3:0] dly = 4'h3;
  logic fault_in = 1'b0;
  logic [7:0] code_in = 8'h01;
  logic peer_in = 1'b0;
  logic [15:0] bus_rdata, v;
  logic [27:0] erase_lba;
  logic [8:0] erase_count;
  logic [7:0] diag_code;
  logic irq, erase_req, erase_done, erase_fault, diag_req, diag_done;
  logic peer_diag_fail, flush_req, flush_done;
  int err_count = 0;
  int compares = 0;

  always #12.5 sys_clk = ~sys_clk;

  apd_cmd_unit apd_cmd_unit_inst (.sys_clk, .rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata, .irq, .pwr_standby, .pwr_transit, .erase_req, .erase_lba, .erase_count,
    .erase_done, .erase_fault, .diag_req, .diag_done, .diag_code, .peer_diag_fail,
    .flush_req, .flush_done);
  apd_media_model apd_media_model_inst (.sys_clk, .rst, .erase_req, .diag_req, .flush_req,
    .dly, .fault_in, .code_in, .peer_in, .erase_done, .erase_fault, .diag_done, .diag_code,
    .peer_diag_fail, .flush_done);

  // ****************************************
  // bus tasks
  // ****************************************
  task automatic results();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask
  // read data appear in the cycle after the strobe and hold until the next read
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask
  // issue an opcode, poll status until not busy, bounded
  task automatic run(input logic [7:0] op, input logic [15:0] st);
    int n;
    n = 0;
    wr(apd_pkg::A_CMD, {8'h00, op});
    v = 16'h0080;
    while (v[7] && n < 40)
    begin
      rd(apd_pkg::A_STAT, v);
      n++;
    end
    if (v[7] !== 1'b0)
    begin
      err_count++;
      $display("ERROR %0t command hung", $time);
      results();
    end
    else
      chk(v, st);
  endtask
  function automatic logic [15:0] id_word(input int i);
    case (i)
      0: return 16'h044a;
      20, 21: return 16'h0002;
      50: return 16'h4000;
      51: return 16'h0200;
      53: return 16'h0007;
      64: return 16'h0003;
      65, 66, 67, 68: return 16'h0078;
      76: return 16'h0006;
      78: return 16'h0008;
      default: return 16'h0000;
    endcase
  endfunction

  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(apd_pkg::A_STAT, v);
    chk(v, 16'h0050);
    rd(apd_pkg::A_ERR, v);
    chk(v, 16'h0001);
    rd(4'hf, v);
    chk(v, 16'h0000);
    wr(apd_pkg::A_IEN, 16'h0007);
    // both opcodes in standby, transition and idle; unused drive/head bits set
    for (int i = 0; i < 6; i++)
    begin
      // power level inputs move only on a clock edge
      @(posedge sys_clk);
      pwr_standby <= (i % 3 == 0);
      pwr_transit <= (i % 3 == 1);
      wr(apd_pkg::A_DRHD, 16'h00ef);
      run(i < 3 ? 8'h98 : 8'he5, 16'h0050);
      rd(apd_pkg::A_SCNT, v);
      chk(v, (i % 3 == 2) ? 16'h00ff : 16'h0000);
      chk(irq, 1'b1);
    end
    rd(apd_pkg::A_ISTAT, v);
    chk(v, 16'h0001);
    wr(apd_pkg::A_IEN, 16'h0000);
    @(posedge sys_clk);
    #1 chk(irq, 1'b0);
    wr(apd_pkg::A_IEN, 16'h0007);
    wr(apd_pkg::A_ICLR, 16'h0007);
    @(posedge sys_clk);
    #1 chk(irq, 1'b0);
    $display("test power query done");
    // erase: zero count means 256 and a faulted finish, then count 5 clean
    wr(apd_pkg::A_SNUM, 16'h0012);
    wr(apd_pkg::A_CYLO, 16'h0034);
    wr(apd_pkg::A_CYHI, 16'h0056);
    wr(apd_pkg::A_DRHD, 16'h00ea);
    for (int i = 0; i < 2; i++)
    begin
      wr(apd_pkg::A_SCNT, i ? 16'h0005 : 16'h0000);
      fault_in <= (i == 0);
      dly <= i ? 4'h1 : 4'h9;
      run(8'hc0, i ? 16'h0050 : 16'h0071);
      chk(erase_lba, 28'ha563412);
      chk(erase_count, i ? 9'h005 : 9'h100);
      // the level output trails the done event by two edges
      @(posedge sys_clk);
      #1 chk(irq, 1'b1);
    end
    $display("test erase done");
    // every diagnostic code, drive bit set, peer failure on the last
    wr(apd_pkg::A_DRHD, 16'h0010);
    for (int c = 1; c < 6; c++)
    begin
      code_in <= 8'(c);
      peer_in <= (c == 5);
      run(8'h90, 16'h0050);
      rd(apd_pkg::A_ERR, v);
      chk(v, 16'(c) | ((c == 5) ? 16'h0080 : 16'h0000));
    end
    $display("test diagnostic done");
    wr(apd_pkg::A_DRHD, 16'h0000);
    run(8'he7, 16'h0050);
    wr(apd_pkg::A_CTRL, 16'h0000);
    run(8'he7, 16'h0051);
    rd(apd_pkg::A_ERR, v);
    chk(v, 16'h0004);
    wr(apd_pkg::A_CTRL, 16'h0001);
    $display("test flush done");
    // other drive selected: query ignored, status and sector count untouched
    wr(apd_pkg::A_DRHD, 16'h0010);
    run(8'h98, 16'h0051);
    rd(apd_pkg::A_SCNT, v);
    chk(v, 16'h0005);
    wr(apd_pkg::A_DRHD, 16'h0000);
    run(8'hec, 16'h0058);
    for (int i = 0; i < 256; i++)
    begin
      rd(apd_pkg::A_DATA, v);
      chk(v, id_word(i));
    end
    rd(apd_pkg::A_STAT, v);
    chk(v, 16'h0050);
    $display("test identify done");
    results();
  end
endmodule
